// *** hpsp_cfg.svh ***
`ifndef HPSP_CFG_SVH
`define HPSP_CFG_SVH
// Clock and timing figures; times in their own unit, counts derived.
`define HPSP_CLK_HZ 10000000
`define HPSP_STARTUP_MS 500
`define HPSP_STARTUP_CYC ((`HPSP_STARTUP_MS * `HPSP_CLK_HZ) / 1000)
`define HPSP_FLASH_MIN_MS 50
`define HPSP_FLASH_MAX_MS 100
`define HPSP_FLASH_CYC ((`HPSP_FLASH_MIN_MS * `HPSP_CLK_HZ + 999) / 1000)
`define HPSP_BAUD 115200
`define HPSP_BIT_CYC (`HPSP_CLK_HZ / `HPSP_BAUD)
// APB register byte offsets.
`define HPSP_ADDR_CTRL 12'h000
`define HPSP_ADDR_STATUS 12'h004
`define HPSP_ADDR_TXDATA 12'h008
`define HPSP_ADDR_RXDATA 12'h00C
// Control field positions.
`define HPSP_CTRL_MODE_LSB 0
`define HPSP_CTRL_DTR_LINK 2
`define HPSP_CTRL_DTR 3
`define HPSP_CTRL_SEL0 4
`define HPSP_CTRL_SEL1 5
`define HPSP_CTRL_RESET 32'h0000_0000
// Status field positions.
`define HPSP_ST_DEFAULT_REQ 0
`define HPSP_ST_FACTORY_REQ 1
`define HPSP_ST_WINDOW_DONE 2
`define HPSP_ST_FUNC_SW 3
`define HPSP_ST_DSR 4
`define HPSP_ST_CTS 5
`define HPSP_ST_RX_VALID 6
`define HPSP_ST_TX_FULL 7
`define HPSP_ST_TX_BUSY 8
`define HPSP_ST_RX_OVERRUN 9
`define HPSP_FIFO_DEPTH 32
`define HPSP_FIFO_AW 5
`endif

// *** hpsp_pkg.sv ***
package hpsp_pkg;
  // Link state chosen by software, drives indicators and optional DTR.
  typedef enum logic [1:0] {HPSP_IDLE = 2'b00, HPSP_CONNECTING = 2'b01, HPSP_CONNECTED = 2'b11} hpsp_mode_e;
  // Transmit framer states, Gray-coded along start, data, stop.
  typedef enum logic [1:0] {HPSP_TX_IDLE = 2'b00, HPSP_TX_START = 2'b01, HPSP_TX_DATA = 2'b11,
                            HPSP_TX_STOP = 2'b10} hpsp_tx_e;
  typedef logic [7:0] hpsp_byte_t;
endpackage : hpsp_pkg

// *** hpsp_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none
module hpsp_fifo
  import hpsp_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = 5
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
    logic [WIDTH-1:0] dout;
  } hpsp_fifo_s;

  hpsp_fifo_s st;
  hpsp_fifo_s next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////
  // Full and empty come from the count, so the depth is used whole.
  assign in_ready = (st.count != DEPTH[AW:0]);
  assign out_valid = (st.count != '0);
  assign out_data = st.dout;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update.
  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.wr = st.wr + 1'b1;
    end
    if (pop)
    begin
      next_st.rd = st.rd + 1'b1;
    end
    next_st.count = st.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // The head word is registered; a write into the slot about to be read
    // bypasses the array, otherwise a lone entry would show stale data.
    next_st.dout = (push && (st.wr == next_st.rd)) ? in_data : mem[next_st.rd];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Storage carries no reset; only written entries are ever read.
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[st.wr] <= in_data;
    end
  end
endmodule : hpsp_fifo
`default_nettype wire

// *** hpsp_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module hpsp_sync
  import hpsp_pkg::*;
#(
  parameter int N = 6,
  parameter logic [N-1:0] INIT = '1
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [N-1:0] pin,
  output logic [N-1:0] level
);
  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] lvl;
  } hpsp_sync_s;

  hpsp_sync_s st;
  hpsp_sync_s next_st;

  ////////////////////////////////////////////////////////////////////////
  // A change is accepted only once stages two and three agree; stage one
  // feeds stage two alone.
  always_comb
  begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < N; i++)
    begin
      if (st.s2[i] == st.s3[i])
      begin
        next_st.lvl[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= {INIT, INIT, INIT, INIT};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign level = st.lvl;
endmodule : hpsp_sync
`default_nettype wire

// *** hpsp_host_port.sv ***
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "hpsp_cfg.svh"
// Behaviour
// R1 - Low function switch triggers external-connect
// R2 - Both straps low at startup: factory restore
// R3 - Green pin shared with default strap
// R4 - Green active low, valid after 500ms
// R5 - Default strap low restores serial defaults
// R6 - Strap sampled only in first 500ms
// R7 - Blue active low, flickers during transmit
// R8 - CTS and RTS active-low flow control
// R9 - Data lines carry bits uninverted
// R10 - DSR input, DTR output, both active low
// R11 - Drive two transceiver select outputs
// R12 - Activity pulses active indicators high briefly; the code pulses only blue
// R13 - DTR optionally shows wireless link active
// R14 - Cycle counter closes strap window
// R15 - RTS deasserted while receive buffer full
module hpsp_host_port
  import hpsp_pkg::*;
#(
  parameter int STARTUP_CYC = `HPSP_STARTUP_CYC,
  parameter int FLASH_CYC = `HPSP_FLASH_CYC
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic func_switch_n,
  input wire logic green_strap_in,
  output logic green_n_out,
  output logic green_n_oe,
  output logic blue_n,
  input wire logic cts_n,
  output logic rts_n,
  output logic txd,
  input wire logic rxd,
  output logic dtr_n,
  input wire logic dsr_n,
  output logic transceiver_select_0,
  output logic transceiver_select_1,
  output logic connect_request,
  output logic default_restore,
  output logic factory_restore
);
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] ctrl;
    logic [22:0] boot_cnt;
    logic window_done;
    logic default_req;
    logic factory_req;
    logic [20:0] flash_cnt;
    logic green_n_out;
    logic green_n_oe;
    logic blue_n;
    logic rts_n;
    logic txd;
    logic dtr_n;
    logic sel0;
    logic sel1;
    logic connect_request;
    hpsp_tx_e tx_state;
    logic [9:0] tx_div;
    logic [2:0] tx_bit;
    hpsp_byte_t tx_shift;
    logic rx_busy;
    logic [9:0] rx_div;
    logic [3:0] rx_bit;
    hpsp_byte_t rx_shift;
    hpsp_byte_t rx_data;
    logic rx_valid;
    logic rx_overrun;
  } hpsp_state_s;

  localparam logic [9:0] BIT_CYC = 10'(`HPSP_BIT_CYC);
  localparam logic [22:0] START_LAST = 23'(STARTUP_CYC - 1);
  localparam logic [20:0] FLASH_LAST = 21'(FLASH_CYC - 1);

  hpsp_state_s st;
  hpsp_state_s next_st;
  logic [4:0] pins;
  logic func_sw_s;
  logic strap_s;
  logic cts_s;
  logic rxd_s;
  logic dsr_s;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  hpsp_byte_t fifo_out_data;
  logic wr_tx;
  logic rd_rx;
  logic setup_acc;
  hpsp_mode_e mode;

  ////////////////////////////////////////////////////////////////////////
  // All pins from the host pass the three-stage filter.
  hpsp_sync #(
    .N(5),
    .INIT(5'h1F)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .pin({func_switch_n, green_strap_in, cts_n, rxd, dsr_n}),
    .level(pins)
  );
  assign func_sw_s = pins[4];
  assign strap_s = pins[3];
  assign cts_s = pins[2];
  assign rxd_s = pins[1];
  assign dsr_s = pins[0];

  // Transmit bytes queue here; a full queue stalls the bus write.
  hpsp_fifo #(
    .WIDTH(8),
    .DEPTH(`HPSP_FIFO_DEPTH),
    .AW(`HPSP_FIFO_AW)
  ) u_txq (
    .clk(clk),
    .resetn(resetn),
    .in_valid(wr_tx),
    .in_ready(fifo_in_ready),
    .in_data(pwdata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus decode; a transmit write in the access phase waits for room.
  assign setup_acc = psel && penable && !st.pready;
  assign wr_tx = setup_acc && pwrite && (paddr == `HPSP_ADDR_TXDATA);
  assign rd_rx = setup_acc && !pwrite && (paddr == `HPSP_ADDR_RXDATA);
  assign mode = hpsp_mode_e'(st.ctrl[`HPSP_CTRL_MODE_LSB +: 2]);
  // Sending stops while the host holds CTS high.
  assign fifo_out_ready = (st.tx_state == HPSP_TX_IDLE) && !cts_s; // see R8

  always_comb
  begin
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    // APB slave: one wait state, longer for a write into a full queue.
    if (setup_acc && (!wr_tx || fifo_in_ready))
    begin
      next_st.pready = 1'b1;
      next_st.prdata = 32'h0000_0000;
      case (paddr)
        `HPSP_ADDR_CTRL:
        begin
          if (pwrite)
          begin
            next_st.ctrl = pwdata[5:0];
          end
          next_st.prdata = {26'h0, st.ctrl};
        end
        `HPSP_ADDR_STATUS:
        begin
          next_st.prdata = {22'h0, st.rx_overrun, st.tx_state != HPSP_TX_IDLE, !fifo_in_ready,
                            st.rx_valid, !cts_s, !dsr_s, !func_sw_s, st.window_done,
                            st.factory_req, st.default_req};
        end
        `HPSP_ADDR_TXDATA:
        begin
          next_st.prdata = 32'h0000_0000;
        end
        `HPSP_ADDR_RXDATA:
        begin
          next_st.prdata = {24'h0, st.rx_data};
          if (rd_rx)
          begin
            next_st.rx_valid = 1'b0;
            next_st.rx_overrun = 1'b0;
          end
        end
        default:
        begin
          next_st.pslverr = 1'b1;
        end
      endcase
    end

    // Startup window counted from reset release; a low strap is latched in any cycle inside it.
    if (!st.window_done)
    begin
      next_st.boot_cnt = st.boot_cnt + 23'h000001; // see R14
      if (!strap_s)
      begin
        next_st.default_req = 1'b1; // see R5, R6
        if (!func_sw_s)
        begin
          next_st.factory_req = 1'b1; // see R2
        end
      end
      if (st.boot_cnt == START_LAST)
      begin
        next_st.window_done = 1'b1; // see R14, R6
      end
    end

    // The shared pin listens during the window, then drives green.
    next_st.green_n_oe = st.window_done; // see R3
    next_st.connect_request = st.window_done && !func_sw_s; // see R1

    // Activity flash: traffic in a link state holds the blue lamp high.
    if ((mode != HPSP_IDLE) && (fifo_out_valid || st.rx_busy))
    begin
      next_st.flash_cnt = FLASH_LAST; // see R12
    end
    else if (st.flash_cnt != 21'h000000)
    begin
      next_st.flash_cnt = st.flash_cnt - 21'h000001;
    end
    next_st.green_n_out = !st.window_done || (mode != HPSP_IDLE); // see R4
    next_st.blue_n = (mode == HPSP_IDLE) || (st.flash_cnt != 21'h000000)
                     || st.tx_bit[2]; // see R7, R12

    // Modem control and transceiver selects.
    next_st.rts_n = st.rx_valid; // see R15, R8
    next_st.dtr_n = st.ctrl[`HPSP_CTRL_DTR_LINK] ? (mode != HPSP_CONNECTED)
                    : !st.ctrl[`HPSP_CTRL_DTR]; // see R10, R13
    next_st.sel0 = st.ctrl[`HPSP_CTRL_SEL0]; // see R11
    next_st.sel1 = st.ctrl[`HPSP_CTRL_SEL1]; // see R11

    // Transmit framer, 8N1, bits sent without inversion.
    next_st.tx_div = (st.tx_div == 10'h000) ? BIT_CYC - 10'h001 : st.tx_div - 10'h001;
    case (st.tx_state)
      HPSP_TX_IDLE:
      begin
        next_st.txd = 1'b1;
        if (fifo_out_valid && !cts_s)
        begin
          next_st.tx_shift = fifo_out_data;
          next_st.tx_state = HPSP_TX_START;
          next_st.tx_div = BIT_CYC - 10'h001;
          next_st.txd = 1'b0;
        end
      end
      HPSP_TX_START:
      begin
        if (st.tx_div == 10'h000)
        begin
          next_st.txd = st.tx_shift[0]; // see R9
          next_st.tx_bit = 3'h0;
          next_st.tx_state = HPSP_TX_DATA;
        end
      end
      HPSP_TX_DATA:
      begin
        if (st.tx_div == 10'h000)
        begin
          if (st.tx_bit == 3'h7)
          begin
            next_st.txd = 1'b1;
            next_st.tx_state = HPSP_TX_STOP;
          end
          else
          begin
            next_st.tx_bit = st.tx_bit + 3'h1;
            next_st.tx_shift = {1'b0, st.tx_shift[7:1]};
            next_st.txd = st.tx_shift[1]; // see R9
          end
        end
      end
      HPSP_TX_STOP:
      begin
        if (st.tx_div == 10'h000)
        begin
          next_st.tx_state = HPSP_TX_IDLE;
        end
      end
      default:
      begin
        next_st.tx_state = HPSP_TX_IDLE;
      end
    endcase
    // Receiver: sample mid-bit; a high line reads as a one.
    if (!st.rx_busy)
    begin
      if (!rxd_s)
      begin
        next_st.rx_busy = 1'b1;
        next_st.rx_div = BIT_CYC >> 1;
        next_st.rx_bit = 4'h0;
      end
    end
    else if (st.rx_div != 10'h000)
    begin
      next_st.rx_div = st.rx_div - 10'h001;
    end
    else
    begin
      next_st.rx_div = BIT_CYC - 10'h001;
      next_st.rx_bit = st.rx_bit + 4'h1;
      if (st.rx_bit == 4'h0 && rxd_s)
      begin
        next_st.rx_busy = 1'b0;
      end
      else if (st.rx_bit == 4'h9)
      begin
        next_st.rx_busy = 1'b0;
        if (st.rx_valid && !rd_rx)
        begin
          next_st.rx_overrun = 1'b1;
        end
        else
        begin
          next_st.rx_data = st.rx_shift; // see R9
          next_st.rx_valid = 1'b1; // Set wins over a same-cycle read.
        end
      end
      else if (st.rx_bit != 4'h0)
      begin
        next_st.rx_shift = {rxd_s, st.rx_shift[7:1]}; // see R9
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lamps and modem lines rest inactive high during reset.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= '0;
      st.ctrl <= 6'(`HPSP_CTRL_RESET);
      st.green_n_out <= 1'b1;
      st.blue_n <= 1'b1;
      st.rts_n <= 1'b1;
      st.txd <= 1'b1;
      st.dtr_n <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register.
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign green_n_out = st.green_n_out;
  assign green_n_oe = st.green_n_oe;
  assign blue_n = st.blue_n;
  assign rts_n = st.rts_n;
  assign txd = st.txd;
  assign dtr_n = st.dtr_n;
  assign transceiver_select_0 = st.sel0;
  assign transceiver_select_1 = st.sel1;
  assign connect_request = st.connect_request;
  assign default_restore = st.default_req;
  assign factory_restore = st.factory_req;
endmodule : hpsp_host_port
`default_nettype wire

// *** hpsp_host_port_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
// Watches the host pins and the register bus for timing faults.
module hpsp_host_port_checker
  import hpsp_pkg::*;
#(
  parameter int STARTUP_CYC = 200,
  parameter int FLASH_CYC = 20
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic green_n_oe,
  input wire logic txd,
  input wire logic transceiver_select_0,
  input wire logic transceiver_select_1,
  input wire logic connect_request,
  input wire logic default_restore,
  input wire logic factory_restore
);
  int cnt;
  logic [1:0] sel_wr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  // Cycles since reset release; it saturates so a long run never wraps.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= 0;
      sel_wr <= 2'h0;
    end
    else
    begin
      if (cnt < STARTUP_CYC + 8)
        cnt <= cnt + 1;
      if (psel && penable && pready && pwrite && paddr == 12'h000)
        sel_wr <= pwdata[5:4];
    end
  end
  ////////////////////////////////////////
  // Steps of a control write and of a transmitted frame.
  sequence s_ctrl_wr;
    psel && penable && pready && pwrite && paddr == 12'h000;
  endsequence
  sequence s_start;
    $fell(txd);
  endsequence
  a_green_off_early: assert property (cnt < STARTUP_CYC |-> !green_n_oe)
    else $error("green pin driven inside strap window");
  a_green_on_late: assert property (cnt == STARTUP_CYC + 8 |-> green_n_oe)
    else $error("green pin not driven after window");
  a_strap_in_window: assert property ($rose(default_restore) |-> cnt <= STARTUP_CYC + 6)
    else $error("strap taken after window");
  a_factory_needs_both: assert property (factory_restore |-> default_restore)
    else $error("factory restore without strap");
  a_connect_after_window: assert property (connect_request |-> cnt >= STARTUP_CYC)
    else $error("connect request inside window");
  a_ready_in_access: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside access or too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_sel_follows_ctrl: assert property (s_ctrl_wr |=> ##[0:2]
    {transceiver_select_1, transceiver_select_0} == sel_wr)
    else $error("selects do not follow control");
  a_start_bit_low: assert property (s_start |=> !txd [*8])
    else $error("start bit too short");
endmodule : hpsp_host_port_checker
bind hpsp_host_port hpsp_host_port_checker #(.STARTUP_CYC(STARTUP_CYC), .FLASH_CYC(FLASH_CYC)) u_chk (
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .green_n_oe(green_n_oe), .txd(txd),
  .transceiver_select_0(transceiver_select_0), .transceiver_select_1(transceiver_select_1),
  .connect_request(connect_request), .default_restore(default_restore), .factory_restore(factory_restore));
`default_nettype wire

// *** hpsp_host_uart.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "hpsp_cfg.svh"
// Host controller on the far side of the serial lines.
module hpsp_host_uart
  import hpsp_pkg::*;
(
  input wire logic clk,
  input wire logic txd,
  input wire logic stall,
  output logic rxd,
  output logic cts_n
);
  localparam int BIT = `HPSP_BIT_CYC;
  hpsp_byte_t got[$];
  // Line idles high and the host holds off until told otherwise.
  initial
  begin
    rxd = 1'b1;
    cts_n = 1'b1;
  end
  // Clear-to-send goes low while the host can take bytes.
  always @(posedge clk)
    cts_n <= stall;
  ////////////////////////////////////////
  // Sends one frame, each bit held for a whole bit time.
  task automatic send(input hpsp_byte_t b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      rxd <= f[i];
      repeat (BIT - 1) @(posedge clk);
    end
  endtask : send
  // Samples each bit at its centre; a bad stop bit drops the byte.
  initial
  begin : rx
    hpsp_byte_t b;
    forever
    begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT) @(posedge clk);
        b[i] = txd;
      end
      repeat (BIT) @(posedge clk);
      if (txd === 1'b1)
        got.push_back(b);
    end
  end
endmodule : hpsp_host_uart
`default_nettype wire

// *** host_port_strap_and_status_pins_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module host_port_strap_and_status_pins_test
  import hpsp_pkg::*;
;
  localparam int SU = 200;
  logic clk, resetn, psel, penable, pwrite, func_switch_n, strap_lvl, dsr_n, stall, pready, pslverr;
  logic green_strap_in, green_n_out, green_n_oe, blue_n, cts_n, rts_n, txd, rxd, dtr_n;
  logic sel0, sel1, conn, dflt, fact, err, watch, bh, bl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] c;
  hpsp_byte_t b1, b2, exp_q[$];
  int n_errors, n_tests, k;
  // Shared lamp and strap pin; an absent strap leaves the pull-up.
  assign green_strap_in = green_n_oe ? green_n_out : strap_lvl;
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  hpsp_host_port #(.STARTUP_CYC(SU), .FLASH_CYC(20)) u_dut (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .func_switch_n(func_switch_n), .green_strap_in(green_strap_in),
    .green_n_out(green_n_out), .green_n_oe(green_n_oe), .blue_n(blue_n), .cts_n(cts_n), .rts_n(rts_n),
    .txd(txd), .rxd(rxd), .dtr_n(dtr_n), .dsr_n(dsr_n), .transceiver_select_0(sel0),
    .transceiver_select_1(sel1), .connect_request(conn), .default_restore(dflt), .factory_restore(fact));
  hpsp_host_uart u_host (.clk(clk), .txd(txd), .stall(stall), .rxd(rxd), .cts_n(cts_n));
  // Records both lamp levels while a transfer is watched.
  always @(posedge clk)
    if (watch)
    begin
      bh |= blue_n;
      bl |= !blue_n;
    end
  ////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task close_out;
    $display("%0d checks, %0d errors", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  // One bus transfer; the request stands until ready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 2000);
    chk(32'(k < 2000), 32'h1);
    if (k >= 2000)
      close_out;
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task rst(input logic s, input logic f);
    {strap_lvl, func_switch_n, resetn} <= {s, f, 1'b0};
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
  endtask : rst
  // Terminal ready is low when forced, or when it tracks a live link.
  function logic exp_dtr(input logic [5:0] v);
    return ~(v[2] ? v[1:0] == 2'b11 : v[3]);
  endfunction : exp_dtr
  ////////////////////////////////////////
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, resetn} = '0;
    {dsr_n, stall, strap_lvl, func_switch_n, watch, bh, bl} = 7'b1111000;
    void'($urandom(32'hCF1FD4A5));
    rst(1'b0, 1'b0);
    repeat (3) @(posedge clk);
    chk(32'({green_n_oe, txd, dtr_n}), 32'h3);
    repeat (SU - 60) @(posedge clk);
    {strap_lvl, func_switch_n} <= 2'b11;
    repeat (80) @(posedge clk);
    chk(32'({dflt, fact, green_n_oe, green_n_out, conn}), 32'h1C);
    apb(1'b0, 12'h004, 32'h0);
    chk(32'(rd[3:0]), 32'h7);
    $display("test straps done");
    rst(1'b1, 1'b1);
    repeat (SU + 20) @(posedge clk);
    func_switch_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'({conn, dflt, fact}), 32'h4);
    func_switch_n <= 1'b1;
    $display("test switch done");
    apb(1'b1, 12'h010, 32'h5A);
    chk(32'(err), 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      c = {2'($urandom), i[1], i[2], i[0] ? 2'b11 : {1'b0, i[1]}};
      apb(1'b1, 12'h000, 32'(c));
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'(c));
      repeat (2) @(posedge clk);
      chk(32'({sel1, sel0, dtr_n, green_n_out}), 32'({c[5:4], exp_dtr(c), c[1:0] != 2'b00}));
    end
    {dsr_n, stall} <= 2'b00;
    repeat (6) @(posedge clk);
    apb(1'b0, 12'h004, 32'h0);
    chk(32'(rd[5:4]), 32'h3);
    $display("test registers done");
    stall <= 1'b1;
    apb(1'b1, 12'h000, 32'h3);
    repeat (6) @(posedge clk);
    for (int i = 0; i < 32; i++)
    begin
      b1 = 8'($urandom);
      exp_q.push_back(b1);
      apb(1'b1, 12'h008, 32'(b1));
    end
    apb(1'b0, 12'h004, 32'h0);
    chk(32'({rd[7], txd, u_host.got.size() == 0}), 32'h7);
    {stall, watch} <= 2'b01;
    k = 0;
    while (u_host.got.size() < 32 && k < 40000)
    begin
      @(posedge clk);
      k++;
    end
    chk(32'(k < 40000), 32'h1);
    if (k >= 40000)
      close_out;
    repeat (100) @(posedge clk);
    chk(32'(u_host.got.size()), 32'd32);
    foreach (u_host.got[i])
      chk(32'(u_host.got[i]), 32'(exp_q[i]));
    chk(32'({bh, bl}), 32'h3);
    $display("test transmit done");
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    u_host.send(b1);
    u_host.send(b2);
    repeat (20) @(posedge clk);
    apb(1'b0, 12'h004, 32'h0);
    chk(32'({rd[9], rd[6], rts_n}), 32'h7);
    apb(1'b0, 12'h00C, 32'h0);
    chk(32'(rd[7:0]), 32'(b1));
    apb(1'b0, 12'h004, 32'h0);
    repeat (3) @(posedge clk);
    chk(32'({rd[9], rd[6], rts_n}), 32'h0);
    $display("test receive done");
    close_out;
  end
endmodule : host_port_strap_and_status_pins_test
`default_nettype wire
